// file: bench/tb.sv
// self-checking bench: register bus, endpoint events, address and stall
`timescale 1ns/100ps
module tb;
  import usb_ep_ctrl_pkg::*;
  logic                  ref_clk, rst_n, hsel, hwrite, rdPhase;
  logic                  usbIntEnable, stackFull;
  logic                  hreadyout, hresp, usbIrq, usbClockGate;
  logic                  suspendCurrentReduction, remoteWakeupAllow;
  logic [1:0]            htrans;
  logic [2:0]            hsize, fifoSelect;
  logic [31:0]           haddr, hwdata, hrdata;
  logic [6:0]            deviceAddress;
  logic [7:0]            epAccess, inStall, v;
  logic                  usbBusReset, setupToken, jStateSuspend, inDataReadDone;
  int                    n_fail, compares;
  logic [31:0]           expQ[$];

  usb_endpoint_status_control #(.NUM_EP(8)) usb_endpoint_status_control_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .epAccess(epAccess),
    .usbBusReset(usbBusReset), .setupToken(setupToken), .jStateSuspend(jStateSuspend),
    .inDataReadDone(inDataReadDone), .usbIntEnable(usbIntEnable), .stackFull(stackFull),
    .usbIrq(usbIrq), .fifoSelect(fifoSelect), .usbClockGate(usbClockGate),
    .suspendCurrentReduction(suspendCurrentReduction), .deviceAddress(deviceAddress),
    .remoteWakeupAllow(remoteWakeupAllow), .inStall(inStall));

  usb_host_model usb_host_model_i (
    .clk(ref_clk), .epAccess(epAccess), .usbBusReset(usbBusReset),
    .setupToken(setupToken), .jStateSuspend(jStateSuspend),
    .inDataReadDone(inDataReadDone));

  task automatic conclude();
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single transfer; hsel stays up so back-to-back calls never double-drive it
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    rdPhase <= ~w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rdPhase <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    expQ.push_back({24'h00_0000, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d});
  endtask

  // read data are matched in issue order at the edge that ends each data phase
  always @(posedge ref_clk) begin
    if (rdPhase && hreadyout === 1'b1) begin
      chk(hrdata, expQ.pop_front());
      chk({31'h0000_0000, hresp}, {31'h0000_0000, HRESP_OKAY});
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // whole run is well under a thousand cycles; this only cuts a hung handshake
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end

  initial begin
    {hsel, hwrite, rdPhase, usbIntEnable, stackFull} = 5'h00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    rst_n = 1'b0;
    void'($urandom(32'h5ece));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // every word starts at zero, and the unmapped word swallows writes
    for (int i = 0; i < 5; i++) rd(32'(i * 4), 8'h00);
    wr(MAP_LIMIT, 8'hFF);
    rd(MAP_LIMIT, 8'h00);
    // random control words; bits 7 and 6 read zero, bit 5 mirrors the line
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[2:0] = 3'(i);
      usb_host_model_i.suspend(v[6]);
      wr(CONTROL_OFFSET, v);
      repeat (2) @(posedge ref_clk);
      rd(CONTROL_OFFSET, {2'b00, v[6], v[4:0]});
      chk(32'(fifoSelect), 32'(v[2:0]));
      chk(32'(usbClockGate), 32'(v[3]));
      chk(32'(suspendCurrentReduction), 32'(v[4] & v[6]));
    end
    wr(CONTROL_OFFSET, 8'h08);
    // each endpoint access sets its own flag and requests the interrupt
    usbIntEnable <= 1'b1;
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      usb_host_model_i.pulse({3'h0, 8'(1 << i)});
      v[i] = 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(32'(usbIrq), 32'h0000_0001);
    end
    rd(FLAGS_OFFSET, v);
    stackFull <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(32'(usbIrq), 32'h0000_0000);
    stackFull <= 1'b0;
    usbIntEnable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(32'(usbIrq), 32'h0000_0000);
    // random gating with every flag set: the request needs the enable and a free stack
    for (int i = 0; i < 8; i++) begin
      {usbIntEnable, stackFull} <= 2'($urandom);
      repeat (2) @(posedge ref_clk);
      chk(32'(usbIrq), 32'(usbIntEnable & ~stackFull));
    end
    usbIntEnable <= 1'b1;
    stackFull <= 1'b0;
    wr(FLAGS_OFFSET, 8'h00);
    rd(FLAGS_OFFSET, 8'h00);
    chk(32'(usbIrq), 32'h0000_0000);
    // a host access landing on the clearing write must survive it
    usb_host_model_i.pulse(11'h001);
    fork
      wr(FLAGS_OFFSET, 8'h00);
      begin
        @(posedge ref_clk);
        usb_host_model_i.pulse(11'h020);
      end
    join
    rd(FLAGS_OFFSET, 8'h20);
    // immediate address update, then the deferred one
    v = 8'($urandom);
    wr(ADDRESS_OFFSET, v);
    repeat (2) @(posedge ref_clk);
    chk(32'(deviceAddress), 32'(v[7:1]));
    chk(32'(remoteWakeupAllow), 32'(v[0]));
    rd(ADDRESS_OFFSET, v);
    wr(METHOD_OFFSET, 8'h01);
    wr(ADDRESS_OFFSET, ~v);
    repeat (2) @(posedge ref_clk);
    chk(32'(deviceAddress), 32'(v[7:1]));
    usb_host_model_i.pulse(11'h400);
    repeat (2) @(posedge ref_clk);
    chk({25'h000_0000, deviceAddress}, {25'h000_0000, ~v[7:1]});
    // stall bits: set by software, setup clears endpoint 0, bus reset clears all
    wr(STALL_OFFSET, 8'hFF);
    rd(STALL_OFFSET, 8'hFF);
    usb_host_model_i.pulse(11'h200);
    repeat (2) @(posedge ref_clk);
    chk(32'(inStall), 32'h0000_00FE);
    usb_host_model_i.pulse(11'h100);
    repeat (2) @(posedge ref_clk);
    chk(32'(inStall), 32'h0000_0000);
    rd(STALL_OFFSET, 8'h00);
    repeat (2) @(posedge ref_clk);
    conclude();
  end
endmodule

// file: bench/usb_host_model.sv
// far-side model: host traffic and link state events seen by the block
`timescale 1ns/100ps
module usb_host_model (
  input  wire logic       clk,
  output logic [7:0]      epAccess,
  output logic            usbBusReset,
  output logic            setupToken,
  output logic            jStateSuspend,
  output logic            inDataReadDone
);
  // all events quiet and the line out of suspend from time zero
  initial begin
    {inDataReadDone, setupToken, usbBusReset, epAccess} = 11'h000;
    jStateSuspend = 1'b0;
  end

  // one-cycle pulses, launched right after an edge so the block samples them once
  task automatic pulse(input logic [10:0] ev);
    {inDataReadDone, setupToken, usbBusReset, epAccess} <= ev;
    @(posedge clk);
    {inDataReadDone, setupToken, usbBusReset, epAccess} <= 11'h000;
  endtask

  // line state is a level: it may sit in suspend for any length of time
  task automatic suspend(input logic j);
    jStateSuspend <= j;
  endtask
endmodule

// file: core/ahb_reg_port.sv
// ahb-lite slave front end: address phase capture and one wait state
`timescale 1ns/100ps
module ahb_reg_port
  import usb_ep_ctrl_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rstSync_n,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic [INDEX_WIDTH-1:0]       regIndex,
  output logic                         mapped,
  output logic                         wrStrobe,
  output logic                         rdStrobe
);

  portState_t state;
  logic       isWrite;

  // one wait state lets a write land before a following read samples
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state     <= PORT_IDLE;
      hreadyout <= 1'b1;
      isWrite   <= 1'b0;
      regIndex  <= '0;
      mapped    <= 1'b0;
    end else begin
      unique case (state)
        PORT_IDLE: begin
          if (hsel && hready && htrans == HTRANS_NONSEQ) begin
            state     <= PORT_DATA;
            hreadyout <= 1'b0;
            isWrite   <= hwrite;
            regIndex  <= haddr[INDEX_WIDTH+1:2];
            mapped    <= haddr < MAP_LIMIT; // above the map reads zero
          end
        end
        PORT_DATA: begin
          state     <= PORT_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // strobes last the single wait cycle, while hwdata stands
  assign wrStrobe = state == PORT_DATA && isWrite;
  assign rdStrobe = state == PORT_DATA && !isWrite;

endmodule

// file: core/usb_endpoint_status_control.sv
// usb endpoint access flags, clock and suspend control, address and in stall
`timescale 1ns/100ps

// How it works
// - host access to endpoint sets its flag
// - set flag raises irq if enabled, stack free
// - eight read/write flags, bit n is endpoint n
// - control bit 5 reads j-state suspend
// - control bit 4 enables suspend current reduction
// - control bit 3 gates usb clock, resets 0
// - bits 2..0 select endpoint fifo, binary coded
// - address and wake register resets to zero
// - method bit picks immediate or delayed address
// - method 0 immediate, 1 after in data read
// - bits 7..1 hold seven-bit device address
// - address bit 0 allows remote wake-up
// - eight in stall bits, bit n endpoint n
// - usb bus reset clears every in stall
// - setup token clears endpoint 0 in stall
module usb_endpoint_status_control
  import usb_ep_ctrl_pkg::*;
#(
  parameter int NUM_EP = 8
) (
  input  wire logic                                ref_clk,
  input  wire logic                                rst_n,
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic                                     hreadyout,
  output logic [31:0]                              hrdata,
  output logic                                     hresp,
  input  wire logic [NUM_EP-1:0]                   epAccess,
  input  wire logic                                usbBusReset,
  input  wire logic                                setupToken,
  input  wire logic                                jStateSuspend,
  input  wire logic                                inDataReadDone,
  input  wire logic                                usbIntEnable,
  input  wire logic                                stackFull,
  output logic                                     usbIrq,
  output logic [usb_ep_ctrl_pkg::SELECT_WIDTH-1:0] fifoSelect,
  output logic                                     usbClockGate,
  output logic                                     suspendCurrentReduction,
  output logic [usb_ep_ctrl_pkg::ADDR_WIDTH-1:0]   deviceAddress,
  output logic                                     remoteWakeupAllow,
  output logic [NUM_EP-1:0]                        inStall
);
  import usb_ep_ctrl_pkg::*;

  // the register layout and select field are fixed at eight endpoints
  if (NUM_EP != REG_WIDTH) begin : g_bad_count
    $error("NUM_EP must be 8");
  end

  logic                   rstMeta_n;
  logic                   rstSync_n;
  logic [INDEX_WIDTH-1:0] regIndex;
  logic                   mapped;
  logic                   wrStrobe;
  logic                   rdStrobe;
  logic [NUM_EP-1:0]      accessFlags;
  logic [REG_WIDTH-1:0]   control;
  logic [REG_WIDTH-1:0]   addrWake;
  logic                   methodLater;
  logic                   jStateSeen;
  logic [REG_WIDTH-1:0]   readWord;
  logic                   wrFlags;
  logic                   wrControl;
  logic                   wrAddress;
  logic                   wrStall;
  logic                   wrMethod;

  // reset released through two flops so every flop leaves reset together
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  ahb_reg_port u_port (
    .clk       (ref_clk),
    .rstSync_n (rstSync_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .regIndex  (regIndex),
    .mapped    (mapped),
    .wrStrobe  (wrStrobe),
    .rdStrobe  (rdStrobe)
  );

  // write decode; unmapped writes are dropped
  assign wrFlags   = wrStrobe && mapped && regIndex == FLAGS_OFFSET[INDEX_WIDTH+1:2];
  assign wrControl = wrStrobe && mapped && regIndex == CONTROL_OFFSET[INDEX_WIDTH+1:2];
  assign wrAddress = wrStrobe && mapped && regIndex == ADDRESS_OFFSET[INDEX_WIDTH+1:2];
  assign wrStall   = wrStrobe && mapped && regIndex == STALL_OFFSET[INDEX_WIDTH+1:2];
  assign wrMethod  = wrStrobe && mapped && regIndex == METHOD_OFFSET[INDEX_WIDTH+1:2];

  // per-endpoint access flags and in stall bits
  for (genvar n = 0; n < NUM_EP; n++) begin : g_ep
    // access by the host outranks a software write in the same cycle
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        accessFlags[n] <= FLAGS_RESET[n];
      end else if (epAccess[n]) begin
        accessFlags[n] <= 1'b1;
      end else if (wrFlags) begin
        accessFlags[n] <= hwdata[n];
      end
    end

    // stall is only set by software; bus events clear and outrank writes
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        inStall[n] <= STALL_RESET[n];
      end else if (usbBusReset) begin
        inStall[n] <= 1'b0;
      end else if (n == 0 && setupToken) begin
        inStall[n] <= 1'b0;
      end else if (wrStall) begin
        inStall[n] <= hwdata[n];
      end
    end
  end

  // interrupt request, gated by the core's enable and stack state
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      usbIrq <= 1'b0;
    end else begin
      usbIrq <= (|accessFlags) && usbIntEnable && !stackFull;
    end
  end

  // control register: all eight bits are stored; bits 7, 6 and 5 are replaced on read
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      control <= CONTROL_RESET;
    end else if (wrControl) begin
      control <= hwdata[REG_WIDTH-1:0];
    end
  end

  // j-state indication is taken from the link every cycle
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      jStateSeen <= 1'b0;
    end else begin
      jStateSeen <= jStateSuspend;
    end
  end

  // control outputs; reduction only acts while the link is suspended
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      usbClockGate            <= 1'b0;
      suspendCurrentReduction <= 1'b0;
      fifoSelect              <= '0;
    end else begin
      usbClockGate            <= control[CLOCK_BIT];
      suspendCurrentReduction <= control[REDUCE_BIT] && jStateSeen;
      fifoSelect              <= control[SELECT_MSB:SELECT_LSB];
    end
  end

  // address and wake register
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      addrWake <= ADDRESS_RESET;
    end else if (wrAddress) begin
      addrWake <= hwdata[REG_WIDTH-1:0];
    end
  end

  assign remoteWakeupAllow = addrWake[WAKE_BIT];

  // address-update method bit
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      methodLater <= METHOD_RESET;
    end else if (wrMethod) begin
      methodLater <= hwdata[METHOD_BIT];
    end
  end

  // live address: follows the register, or waits for a finished in read
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      deviceAddress <= ADDRESS_RESET[ADDR_MSB:ADDR_LSB];
    end else if (!methodLater || inDataReadDone) begin
      deviceAddress <= addrWake[ADDR_MSB:ADDR_LSB];
    end
  end

  // read view of the registers
  always_comb begin
    readWord = '0;
    unique case (regIndex)
      FLAGS_OFFSET[INDEX_WIDTH+1:2]: begin
        readWord = accessFlags;
      end
      CONTROL_OFFSET[INDEX_WIDTH+1:2]: begin
        readWord             = control;
        readWord[7]          = 1'b0; // connection control not built here
        readWord[UNUSED_BIT] = 1'b0;
        readWord[JSTATE_BIT] = jStateSeen;
      end
      ADDRESS_OFFSET[INDEX_WIDTH+1:2]: begin
        readWord = addrWake;
      end
      STALL_OFFSET[INDEX_WIDTH+1:2]: begin
        readWord = inStall;
      end
      METHOD_OFFSET[INDEX_WIDTH+1:2]: begin
        readWord[METHOD_BIT] = methodLater;
      end
      default: begin
        readWord = '0;
      end
    endcase
  end

  // read data registered in the wait cycle; holds until the next read
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rdStrobe) begin
      hrdata <= mapped ? {24'h00_0000, readWord} : 32'h0000_0000;
    end
  end

  // only single word transfers exist, so every answer is okay
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSync_n);

  sequence s_access;
    |epAccess;
  endsequence

  sequence s_immediateWrite;
    wrAddress && !methodLater;
  endsequence

  sequence s_laterLoad;
    methodLater && inDataReadDone && !wrMethod;
  endsequence

  sequence s_controlRead;
    rdStrobe && mapped && regIndex == CONTROL_OFFSET[INDEX_WIDTH+1:2];
  endsequence

  // a flag write with no host access in the same cycle lands as written
  sequence s_flagWrite;
    wrFlags && epAccess == '0;
  endsequence

  a_flag_set_wins: assert property (
    s_access |=> (accessFlags & $past(epAccess)) == $past(epAccess))
    else $error("access flag not set after endpoint access");

  a_flag_holds: assert property (
    (epAccess == '0 && !wrFlags) |=> accessFlags == $past(accessFlags))
    else $error("access flag changed without cause");

  a_irq_cause: assert property (
    ##1 usbIrq == $past((|accessFlags) && usbIntEnable && !stackFull))
    else $error("interrupt does not follow flags and gating");

  a_jstate_read: assert property (
    s_controlRead |=> hrdata[JSTATE_BIT] == $past(jStateSeen) && !hrdata[UNUSED_BIT])
    else $error("control read shows wrong suspend or unused bit");

  a_reduce_gate: assert property (
    ##2 suspendCurrentReduction == ($past(control[REDUCE_BIT]) && $past(jStateSuspend, 2)))
    else $error("current reduction not gated by control and suspend");

  a_clock_gate: assert property (
    wrControl |=> ##1 usbClockGate == $past(control[CLOCK_BIT]))
    else $error("usb clock gate does not follow control");

  a_addr_now: assert property (
    s_immediateWrite |-> ##2 deviceAddress == $past(addrWake[ADDR_MSB:ADDR_LSB]))
    else $error("immediate address not applied in two cycles");

  a_addr_later: assert property (
    (methodLater && !inDataReadDone && !wrMethod) |=> deviceAddress == $past(deviceAddress))
    else $error("delayed address changed before in read finished");

  a_addr_load: assert property (
    s_laterLoad |=> deviceAddress == $past(addrWake[ADDR_MSB:ADDR_LSB]))
    else $error("delayed address not loaded after in read");

  a_stall_reset: assert property (
    usbBusReset |=> inStall == '0)
    else $error("bus reset left an in stall bit set");

  a_stall_setup: assert property (
    setupToken |=> !inStall[0])
    else $error("setup token left endpoint 0 stalled");

  a_wait_state: assert property (
    (hsel && hready && htrans == HTRANS_NONSEQ && hreadyout) |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after exactly one wait cycle");

  a_flag_write: assert property (
    s_flagWrite |=> accessFlags == $past(hwdata[NUM_EP-1:0]))
    else $error("software write did not set the access flags");

  a_stall_write: assert property (
    (wrStall && !usbBusReset && !setupToken) |=> inStall == $past(hwdata[NUM_EP-1:0]))
    else $error("software write did not set the in stall bits");

  // hardware only ever clears stall bits, so a quiet cycle leaves them alone
  a_stall_hold: assert property (
    (!wrStall && !usbBusReset && !setupToken) |=> inStall == $past(inStall))
    else $error("in stall bits changed without a write or bus event");

  // writes sit at least two cycles apart, so the written select is still the one shown
  a_select_follow: assert property (
    wrControl |-> ##2 fifoSelect == $past(hwdata[SELECT_MSB:SELECT_LSB], 2))
    else $error("fifo select does not follow the control write");

  a_wake_follow: assert property (
    wrAddress |=> remoteWakeupAllow == $past(hwdata[WAKE_BIT]))
    else $error("remote wake-up bit does not follow the address write");

endmodule

// file: core/usb_ep_ctrl_pkg.sv
// constants shared by the endpoint status and control block
package usb_ep_ctrl_pkg;

  // register byte offsets on the bus
  localparam logic [31:0] FLAGS_OFFSET    = 32'h0000_0000;
  localparam logic [31:0] CONTROL_OFFSET  = 32'h0000_0004;
  localparam logic [31:0] ADDRESS_OFFSET  = 32'h0000_0008;
  localparam logic [31:0] STALL_OFFSET    = 32'h0000_000C;
  localparam logic [31:0] METHOD_OFFSET   = 32'h0000_0010;
  localparam logic [31:0] MAP_LIMIT       = 32'h0000_0014;

  // word index width and data widths
  localparam int          INDEX_WIDTH     = 3;
  localparam int          REG_WIDTH       = 8;
  localparam int          ADDR_WIDTH      = 7;
  localparam int          SELECT_WIDTH    = 3;

  // control register field positions
  localparam int          UNUSED_BIT      = 6;
  localparam int          JSTATE_BIT      = 5;
  localparam int          REDUCE_BIT      = 4;
  localparam int          CLOCK_BIT       = 3;
  localparam int          SELECT_MSB      = 2;
  localparam int          SELECT_LSB      = 0;

  // address register field positions
  localparam int          ADDR_MSB        = 7;
  localparam int          ADDR_LSB        = 1;
  localparam int          WAKE_BIT        = 0;

  // address-update method register field
  localparam int          METHOD_BIT      = 0;

  // reset values
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  ADDRESS_RESET   = 8'h00;
  localparam logic [7:0]  STALL_RESET     = 8'h00;
  localparam logic        METHOD_RESET    = 1'b0;

  // bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'b0;

  // bus port sequencing
  typedef enum logic {PORT_IDLE, PORT_DATA} portState_t;

endpackage
